// ==== rtl/standby_pkg.sv ====
// Package of constants and types for the standby mode controller
package standby_pkg;

    // ==========================================================
    // Standby select encodings (overridable at the top)
    localparam logic [1:0] SEL_STOP_DEF  = 2'h1;
    localparam logic [1:0] SEL_SLEEP_DEF = 2'h2;
    localparam logic [1:0] SEL_IDLE_DEF  = 2'h3;

    // ==========================================================
    // Peripheral enable vector layout
    localparam int TIMER_PAIRS  = 6;
    localparam int WIDE_TIMERS  = 14;
    localparam int SERIAL_CHANS = 5;
    localparam int POS_PAIR     = 0;
    localparam int POS_WIDE     = 6;
    localparam int POS_SERIAL   = 20;
    localparam int POS_SBUS     = 25;
    localparam int POS_ADC      = 26;
    localparam int POS_WDT      = 27;
    localparam int PERIPH_W     = 28;

    // ==========================================================
    // Warm-up time in microseconds and cycles at 200 MHz
    localparam int WARMUP_US      = 122;
    localparam int CLK_MHZ        = 200;
    localparam int WARMUP_CYCLES  = WARMUP_US * CLK_MHZ;
    localparam int WARM_W         = 16;

    // ==========================================================
    // Mode states
    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_SLOW,
        ST_IDLE_HALT,
        ST_IDLE_DOZE,
        ST_SLEEP,
        ST_STOP,
        ST_WARMUP
    } mode_t;

endpackage : standby_pkg

// ==== rtl/warmup_timer.sv ====
// Oscillator warm-up down counter
`timescale 1ns/1ps
`default_nettype none
module warmup_timer #(
    parameter int          WIDTH   = 16,
    parameter int unsigned CYCLES  = 24400
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    logic [WIDTH-1:0] count_reg;
    logic             busy_reg;
    logic             done_reg;

    // ==========================================================
    // Counter
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count_reg <= '0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start) begin
                count_reg <= WIDTH'(CYCLES - 1);
                busy_reg  <= 1'b1;
            end else if (busy_reg) begin
                if (count_reg == '0) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg - 1'b1;
                end
            end
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
endmodule : warmup_timer
`default_nettype wire

// ==== rtl/standby_mode_controller.sv ====
// Standby mode controller: mode machine and clock gating
//
// Behaviour
// - A halt request in NORMAL enters IDLE, SLEEP or STOP as standby_select chooses.
// - A doze request enters IDLE regardless of standby_select.
// - IDLE gates the CPU clock (halt IDLE also the I/O port clock), keeps oscillator and PLL, and peripherals follow settings.
// - Each timer pair, wide timer, serial channel, serial bus, converter and watchdog has its own IDLE run bit.
// - Halt IDLE freezes the core and refuses the bus to internal DMA.
// - Doze IDLE freezes the core but still grants the bus to outside requesters.
// - SLEEP runs only the low-speed oscillator, real-time clock, pulse counter and key pull-up.
// - STOP halts both oscillators and PLL and removes every clock.
// - NORMAL clocks core and peripherals fully with oscillator and PLL running.
// - SLOW turns the PLL off, keeps the CPU clock, and feeds only the slow-mode peripheral set.
// - Doze IDLE stops execution and each peripheral runs per its run bit.
// - An enabled interrupt or a reset ends any standby mode, wake sources depending on mode.
// - Reset wake reinitialises all settings; interrupt wake keeps them.
`timescale 1ns/1ps
`default_nettype none
module standby_mode_controller #(
    parameter logic [1:0]  SEL_IDLE      = standby_pkg::SEL_IDLE_DEF,
    parameter logic [1:0]  SEL_SLEEP     = standby_pkg::SEL_SLEEP_DEF,
    parameter logic [1:0]  SEL_STOP      = standby_pkg::SEL_STOP_DEF,
    parameter int unsigned WARMUP_CYCLES = standby_pkg::WARMUP_CYCLES
) (
    input  wire logic                            clk_sys,
    input  wire logic                            sys_rst,
    input  wire logic                            halt_req,
    input  wire logic                            doze_req,
    input  wire logic [1:0]                      standby_select,
    input  wire logic                            slow_req,
    input  wire logic [standby_pkg::PERIPH_W-1:0] idle_run,
    input  wire logic                            wake_irq_idle,
    input  wire logic                            wake_irq_sleep,
    input  wire logic                            wake_irq_stop,
    input  wire logic                            dma_req,
    output logic                                 cpu_clk_en,
    output logic                                 high_osc_en,
    output logic                                 low_osc_en,
    output logic                                 pll_en,
    output logic [standby_pkg::PERIPH_W-1:0]     periph_clk_en,
    output logic                                 interrupt_controller_clk_en,
    output logic                                 external_bus_interface_clk_en,
    output logic                                 io_port_clk_en,
    output logic                                 rtc_clk_en,
    output logic                                 pulse_counter_clk_en,
    output logic                                 key_wakeup_pullup_en,
    output logic                                 core_frozen,
    output logic                                 bus_grant,
    output logic [2:0]                           mode_state
);
    standby_pkg::mode_t state_reg;
    standby_pkg::mode_t state_next;
    standby_pkg::mode_t resume_reg;
    logic               warm_start;
    logic               warm_done;

    // ==========================================================
    // Warm-up timer
    warmup_timer #(
        .WIDTH  (standby_pkg::WARM_W),
        .CYCLES (WARMUP_CYCLES)
    ) u_warm (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .start   (warm_start),
        .busy    (),
        .done    (warm_done)
    );

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        warm_start = 1'b0;
        case (state_reg)
            standby_pkg::ST_NORMAL, standby_pkg::ST_SLOW: begin
                if (doze_req) begin
                    state_next = standby_pkg::ST_IDLE_DOZE;
                end else if (halt_req && state_reg == standby_pkg::ST_NORMAL) begin
                    if (standby_select == SEL_SLEEP) begin
                        state_next = standby_pkg::ST_SLEEP;
                    end else if (standby_select == SEL_STOP) begin
                        state_next = standby_pkg::ST_STOP;
                    end else if (standby_select == SEL_IDLE) begin
                        state_next = standby_pkg::ST_IDLE_HALT;
                    end
                end else if (state_reg == standby_pkg::ST_NORMAL && slow_req) begin
                    state_next = standby_pkg::ST_SLOW;
                end else if (state_reg == standby_pkg::ST_SLOW && !slow_req) begin
                    state_next = standby_pkg::ST_NORMAL;
                end
            end
            standby_pkg::ST_IDLE_HALT, standby_pkg::ST_IDLE_DOZE: begin
                if (wake_irq_idle) begin
                    state_next = resume_reg;
                end
            end
            standby_pkg::ST_SLEEP: begin
                if (wake_irq_sleep) begin
                    state_next = standby_pkg::ST_WARMUP;
                    warm_start = 1'b1;
                end
            end
            standby_pkg::ST_STOP: begin
                if (wake_irq_stop) begin
                    state_next = standby_pkg::ST_WARMUP;
                    warm_start = 1'b1;
                end
            end
            standby_pkg::ST_WARMUP: begin
                if (warm_done) begin
                    state_next = resume_reg;
                end
            end
            default: begin
                state_next = standby_pkg::ST_NORMAL;
            end
        endcase
    end

    // ==========================================================
    // State registers; reset wakes to NORMAL
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= standby_pkg::ST_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            resume_reg <= standby_pkg::ST_NORMAL;
        end else if (state_reg == standby_pkg::ST_NORMAL
                     || state_reg == standby_pkg::ST_SLOW) begin
            resume_reg <= state_reg;
        end
    end

    // ==========================================================
    // Clock and bus control outputs

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cpu_clk_en                    <= 1'b1;
            high_osc_en                   <= 1'b1;
            low_osc_en                    <= 1'b1;
            pll_en                        <= 1'b1;
            periph_clk_en                 <= '1;
            interrupt_controller_clk_en   <= 1'b1;
            external_bus_interface_clk_en <= 1'b1;
            io_port_clk_en                <= 1'b1;
            rtc_clk_en                    <= 1'b1;
            pulse_counter_clk_en          <= 1'b1;
            key_wakeup_pullup_en          <= 1'b1;
            core_frozen                   <= 1'b0;
            bus_grant                     <= 1'b0;
        end else begin
            case (state_next)
                standby_pkg::ST_NORMAL: begin
                    cpu_clk_en                    <= 1'b1;
                    high_osc_en                   <= 1'b1;
                    low_osc_en                    <= 1'b1;
                    pll_en                        <= 1'b1;
                    periph_clk_en                 <= '1;
                    interrupt_controller_clk_en   <= 1'b1;
                    external_bus_interface_clk_en <= 1'b1;
                    io_port_clk_en                <= 1'b1;
                    rtc_clk_en                    <= 1'b1;
                    pulse_counter_clk_en          <= 1'b1;
                    key_wakeup_pullup_en          <= 1'b1;
                    core_frozen                   <= 1'b0;
                    bus_grant                     <= dma_req;
                end
                standby_pkg::ST_SLOW: begin
                    cpu_clk_en                    <= 1'b1;
                    high_osc_en                   <= 1'b1;
                    low_osc_en                    <= 1'b1;
                    pll_en                        <= 1'b0;
                    periph_clk_en                 <= '0;
                    periph_clk_en[standby_pkg::POS_WDT] <= 1'b1;
                    interrupt_controller_clk_en   <= 1'b1;
                    external_bus_interface_clk_en <= 1'b1;
                    io_port_clk_en                <= 1'b1;
                    rtc_clk_en                    <= 1'b1;
                    pulse_counter_clk_en          <= 1'b0;
                    key_wakeup_pullup_en          <= 1'b1;
                    core_frozen                   <= 1'b0;
                    bus_grant                     <= dma_req;
                end
                standby_pkg::ST_IDLE_HALT, standby_pkg::ST_IDLE_DOZE: begin
                    cpu_clk_en                    <= 1'b0;
                    high_osc_en                   <= 1'b1;
                    low_osc_en                    <= 1'b1;
                    pll_en                        <= 1'b1;
                    periph_clk_en                 <= idle_run;
                    interrupt_controller_clk_en   <= 1'b1;
                    external_bus_interface_clk_en <= 1'b1;
                    io_port_clk_en                <= (state_next == standby_pkg::ST_IDLE_DOZE);
                    rtc_clk_en                    <= 1'b1;
                    pulse_counter_clk_en          <= 1'b1;
                    key_wakeup_pullup_en          <= 1'b1;
                    core_frozen                   <= 1'b1;
                    bus_grant                     <= (state_next == standby_pkg::ST_IDLE_DOZE)
                                                     && dma_req;
                end
                standby_pkg::ST_SLEEP: begin
                    cpu_clk_en                    <= 1'b0;
                    high_osc_en                   <= 1'b0;
                    low_osc_en                    <= 1'b1;
                    pll_en                        <= 1'b0;
                    periph_clk_en                 <= '0;
                    interrupt_controller_clk_en   <= 1'b0;
                    external_bus_interface_clk_en <= 1'b0;
                    io_port_clk_en                <= 1'b0;
                    rtc_clk_en                    <= 1'b1;
                    pulse_counter_clk_en          <= 1'b1;
                    key_wakeup_pullup_en          <= 1'b1;
                    core_frozen                   <= 1'b1;
                    bus_grant                     <= 1'b0;
                end
                standby_pkg::ST_STOP: begin
                    cpu_clk_en                    <= 1'b0;
                    high_osc_en                   <= 1'b0;
                    low_osc_en                    <= 1'b0;
                    pll_en                        <= 1'b0;
                    periph_clk_en                 <= '0;
                    interrupt_controller_clk_en   <= 1'b0;
                    external_bus_interface_clk_en <= 1'b0;
                    io_port_clk_en                <= 1'b0;
                    rtc_clk_en                    <= 1'b0;
                    pulse_counter_clk_en          <= 1'b0;
                    key_wakeup_pullup_en          <= 1'b0;
                    core_frozen                   <= 1'b1;
                    bus_grant                     <= 1'b0;
                end
                default: begin
                    cpu_clk_en                    <= 1'b0;
                    high_osc_en                   <= 1'b1;
                    low_osc_en                    <= 1'b1;
                    pll_en                        <= (resume_reg == standby_pkg::ST_NORMAL);
                    periph_clk_en                 <= '0;
                    interrupt_controller_clk_en   <= 1'b0;
                    external_bus_interface_clk_en <= 1'b0;
                    io_port_clk_en                <= 1'b0;
                    rtc_clk_en                    <= 1'b1;
                    pulse_counter_clk_en          <= 1'b1;
                    key_wakeup_pullup_en          <= 1'b1;
                    core_frozen                   <= 1'b1;
                    bus_grant                     <= 1'b0;
                end
            endcase
        end
    end

    assign mode_state = state_reg;
endmodule : standby_mode_controller
`default_nettype wire

// ==== tb/standby_mode_monitor.sv ====
// Assertion checker for the standby mode controller ports
`timescale 1ns/1ps
`default_nettype none
module standby_mode_monitor #(
    parameter logic [1:0]  SEL_IDLE      = standby_pkg::SEL_IDLE_DEF,
    parameter logic [1:0]  SEL_SLEEP     = standby_pkg::SEL_SLEEP_DEF,
    parameter logic [1:0]  SEL_STOP      = standby_pkg::SEL_STOP_DEF,
    parameter int unsigned WARMUP_CYCLES = standby_pkg::WARMUP_CYCLES
) (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        halt_req,
    input wire logic        doze_req,
    input wire logic [1:0]  standby_select,
    input wire logic        slow_req,
    input wire logic [27:0] idle_run,
    input wire logic        wake_irq_idle,
    input wire logic        wake_irq_sleep,
    input wire logic        wake_irq_stop,
    input wire logic        dma_req,
    input wire logic        cpu_clk_en,
    input wire logic        high_osc_en,
    input wire logic        low_osc_en,
    input wire logic        pll_en,
    input wire logic [27:0] periph_clk_en,
    input wire logic        interrupt_controller_clk_en,
    input wire logic        external_bus_interface_clk_en,
    input wire logic        io_port_clk_en,
    input wire logic        rtc_clk_en,
    input wire logic        pulse_counter_clk_en,
    input wire logic        key_wakeup_pullup_en,
    input wire logic        core_frozen,
    input wire logic        bus_grant,
    input wire logic [2:0]  mode_state
);
    // ====
    // Mode decode helpers
    localparam int WU = WARMUP_CYCLES;
    wire logic is_norm = mode_state == standby_pkg::ST_NORMAL;
    wire logic is_slow = mode_state == standby_pkg::ST_SLOW;
    wire logic is_halt = mode_state == standby_pkg::ST_IDLE_HALT;
    wire logic is_doze = mode_state == standby_pkg::ST_IDLE_DOZE;
    wire logic is_sleep = mode_state == standby_pkg::ST_SLEEP;
    wire logic is_stop = mode_state == standby_pkg::ST_STOP;
    wire logic [2:0] halt_tgt = (standby_select == SEL_IDLE) ? standby_pkg::ST_IDLE_HALT
        : (standby_select == SEL_SLEEP) ? standby_pkg::ST_SLEEP
        : (standby_select == SEL_STOP) ? standby_pkg::ST_STOP : standby_pkg::ST_NORMAL;
    wire logic is_warm = mode_state == standby_pkg::ST_WARMUP;
    wire logic [3:0] side_v = {interrupt_controller_clk_en, external_bus_interface_clk_en,
        io_port_clk_en, rtc_clk_en};
    int warm_cnt;
    always_ff @(posedge clk_sys) begin
        warm_cnt <= is_warm ? warm_cnt + 1 : 0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ====
    // Wake and warm-up sequences
    sequence s_deep_wake;
        (is_sleep && wake_irq_sleep) or (is_stop && wake_irq_stop);
    endsequence
    sequence s_warm_hold;
        is_warm && !cpu_clk_en && high_osc_en;
    endsequence
    // ====
    // Properties
    a_halt_picks_mode: assert property (
        is_norm && halt_req && !doze_req |=> mode_state == $past(halt_tgt))
        else $error("halt entry mismatch");
    a_doze_to_idle: assert property (
        (is_norm || is_slow) && doze_req |=> is_doze) else $error("doze entry mismatch");
    a_idle_cpu_gated: assert property (
        is_halt || is_doze |-> !cpu_clk_en && high_osc_en && pll_en && core_frozen
        && periph_clk_en == $past(idle_run)) else $error("idle gating mismatch");
    a_halt_keeps_bus: assert property (
        is_halt |-> !bus_grant) else $error("bus granted in halt idle");
    a_doze_grants_bus: assert property (
        is_doze |-> bus_grant == $past(dma_req)) else $error("bus grant in doze idle");
    a_sleep_low_only: assert property (
        is_sleep |-> low_osc_en && rtc_clk_en && pulse_counter_clk_en && key_wakeup_pullup_en
        && !high_osc_en && !pll_en && !cpu_clk_en && periph_clk_en == 28'h000_0000)
        else $error("sleep clock mismatch");
    a_stop_all_off: assert property (
        is_stop |-> !(cpu_clk_en || high_osc_en || low_osc_en || pll_en || (|periph_clk_en)
        || (|side_v) || pulse_counter_clk_en || key_wakeup_pullup_en))
        else $error("clock running in stop");
    a_normal_full_run: assert property (
        is_norm |-> cpu_clk_en && high_osc_en && low_osc_en && pll_en && (&periph_clk_en)
        && (&side_v) && pulse_counter_clk_en && key_wakeup_pullup_en && !core_frozen)
        else $error("normal clock mismatch");
    a_slow_partial_set: assert property (
        is_slow |-> cpu_clk_en && !pll_en && (&side_v) && periph_clk_en == 28'h800_0000)
        else $error("slow clock mismatch");
    a_stop_refuses_wake: assert property (
        is_stop && !wake_irq_stop |=> is_stop) else $error("stop left without wake");
    a_idle_wake_back: assert property (
        (is_halt || is_doze) && wake_irq_idle |=> is_norm || is_slow)
        else $error("idle wake mismatch");
    a_deep_wake_warm: assert property (
        s_deep_wake |=> s_warm_hold) else $error("warm-up entry mismatch");
    a_warm_hold_time: assert property (
        is_warm && warm_cnt < WU |=> s_warm_hold) else $error("warm-up ended early");
    a_warm_exit_time: assert property (
        is_warm && warm_cnt == WU |=> is_norm) else $error("warm-up exit mismatch");
endmodule : standby_mode_monitor
bind standby_mode_controller standby_mode_monitor #(.SEL_IDLE(SEL_IDLE),
    .SEL_SLEEP(SEL_SLEEP), .SEL_STOP(SEL_STOP), .WARMUP_CYCLES(WARMUP_CYCLES)) u_mon (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .halt_req(halt_req), .doze_req(doze_req),
    .standby_select(standby_select), .slow_req(slow_req), .idle_run(idle_run),
    .wake_irq_idle(wake_irq_idle), .wake_irq_sleep(wake_irq_sleep),
    .wake_irq_stop(wake_irq_stop), .dma_req(dma_req), .cpu_clk_en(cpu_clk_en),
    .high_osc_en(high_osc_en), .low_osc_en(low_osc_en), .pll_en(pll_en),
    .periph_clk_en(periph_clk_en), .interrupt_controller_clk_en(interrupt_controller_clk_en),
    .external_bus_interface_clk_en(external_bus_interface_clk_en),
    .io_port_clk_en(io_port_clk_en), .rtc_clk_en(rtc_clk_en),
    .pulse_counter_clk_en(pulse_counter_clk_en), .key_wakeup_pullup_en(key_wakeup_pullup_en),
    .core_frozen(core_frozen), .bus_grant(bus_grant), .mode_state(mode_state));
`default_nettype wire

// ==== tb/core_model.sv ====
// Processor core model issuing halt, doze and bus requests
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic       clk_sys,
    input  wire logic [1:0] op,
    output logic            halt_req,
    output logic            doze_req,
    output logic            dma_req
);
    // ====
    // Halt and doze bits held as levels
    assign halt_req = op == 2'h1;
    assign doze_req = op == 2'h2;
    // ====
    // Outside bus requester
    always @(negedge clk_sys) begin
        dma_req <= 1'($urandom);
    end
endmodule : core_model
`default_nettype wire

// ==== tb/test_standby_mode_controller.sv ====
// Self-checking testbench for the standby mode controller
`timescale 1ns/1ps
`default_nettype none
module test_standby_mode_controller;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [1:0]  op = 2'h0;
    logic [1:0]  standby_select = 2'h0;
    logic        slow_req = 1'b0;
    logic [27:0] idle_run = 28'h000_0000;
    logic        wake_irq_idle = 1'b0;
    logic        wake_irq_sleep = 1'b0;
    logic        wake_irq_stop = 1'b0;
    logic [2:0]  last_mode = 3'h0;
    logic [2:0]  exp_q[$];
    int          err_total = 0;
    int          comparisons = 0;
    wire logic halt_req, doze_req, dma_req, cpu_clk_en, high_osc_en, low_osc_en, pll_en;
    wire logic interrupt_controller_en, external_bus_interface_en, io_en, rtc_en, pulse_en, key_en, core_frozen, bus_grant;
    wire logic [27:0] periph_clk_en;
    wire logic [2:0]  mode_state;
    always #2.5 clk_sys = ~clk_sys;
    core_model u_core (.clk_sys(clk_sys), .op(op), .halt_req(halt_req), .doze_req(doze_req),
        .dma_req(dma_req));
    standby_mode_controller #(.WARMUP_CYCLES(8)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .halt_req(halt_req), .doze_req(doze_req), .standby_select(standby_select),
        .slow_req(slow_req), .idle_run(idle_run), .wake_irq_idle(wake_irq_idle),
        .wake_irq_sleep(wake_irq_sleep), .wake_irq_stop(wake_irq_stop), .dma_req(dma_req),
        .cpu_clk_en(cpu_clk_en), .high_osc_en(high_osc_en), .low_osc_en(low_osc_en),
        .pll_en(pll_en), .periph_clk_en(periph_clk_en), .interrupt_controller_clk_en(interrupt_controller_en),
        .external_bus_interface_clk_en(external_bus_interface_en), .io_port_clk_en(io_en), .rtc_clk_en(rtc_en),
        .pulse_counter_clk_en(pulse_en), .key_wakeup_pullup_en(key_en),
        .core_frozen(core_frozen), .bus_grant(bus_grant), .mode_state(mode_state));
    // ====
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        check(exp_q.size(), 0);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : step
    task automatic pulse_op(input logic [1:0] o);
        op = o;
        step(1);
        op = 2'h0;
    endtask : pulse_op
    task automatic pulse(ref logic w);
        w = 1'b1;
        step(1);
        w = 1'b0;
    endtask : pulse
    // ====
    // Watcher of mode changes against noted expectations
    always @(posedge clk_sys) begin
        #1;
        if (mode_state !== last_mode) begin
            if (exp_q.size() == 0) begin
                exp_q.push_back(last_mode);
            end
            check(mode_state, exp_q.pop_front());
            last_mode = mode_state;
        end
    end
    initial begin
        #20000;
        err_total++;
        complete_run();
    end
    // ====
    // Main sequence
    initial begin
        logic [31:0] rnd;
        logic [2:0]  exp;
        rnd = $urandom(32'h182a_1688);
        step(4);
        sys_rst = 1'b0;
        step(1);
        check({cpu_clk_en, high_osc_en, low_osc_en, pll_en, core_frozen}, 5'h1e);
        for (int i = 0; i < 4; i++) begin
            rnd = $urandom;
            standby_select = 2'(i);
            idle_run = rnd[27:0];
            exp = (standby_select == standby_pkg::SEL_IDLE_DEF) ? standby_pkg::ST_IDLE_HALT
                : (standby_select == standby_pkg::SEL_SLEEP_DEF) ? standby_pkg::ST_SLEEP
                : (standby_select == standby_pkg::SEL_STOP_DEF) ? standby_pkg::ST_STOP
                : standby_pkg::ST_NORMAL;
            if (exp != standby_pkg::ST_NORMAL) begin
                exp_q.push_back(exp);
            end
            pulse_op(2'h1);
            check(mode_state, exp);
            if (exp == standby_pkg::ST_IDLE_HALT) begin
                check({cpu_clk_en, high_osc_en, pll_en, core_frozen, bus_grant}, 5'h0e);
                check(periph_clk_en, idle_run);
                exp_q.push_back(standby_pkg::ST_NORMAL);
                pulse(wake_irq_idle);
            end else if (exp != standby_pkg::ST_NORMAL) begin
                pulse(wake_irq_idle);
                check(mode_state, exp);
                check({cpu_clk_en, |periph_clk_en, high_osc_en, pll_en, low_osc_en, rtc_en,
                    key_en}, (exp == standby_pkg::ST_SLEEP) ? 7'h07 : 7'h00);
                exp_q.push_back(standby_pkg::ST_WARMUP);
                exp_q.push_back(standby_pkg::ST_NORMAL);
                wake_irq_sleep = exp == standby_pkg::ST_SLEEP;
                wake_irq_stop = exp == standby_pkg::ST_STOP;
                step(1);
                wake_irq_sleep = 1'b0;
                wake_irq_stop = 1'b0;
                step(2);
                check({cpu_clk_en, high_osc_en}, 2'h1);
            end
            step(20);
        end
        rnd = $urandom;
        standby_select = rnd[1:0];
        idle_run = rnd[31:4];
        exp_q.push_back(standby_pkg::ST_IDLE_DOZE);
        pulse_op(2'h2);
        check({periph_clk_en, cpu_clk_en, core_frozen}, {idle_run, 2'h1});
        exp_q.push_back(standby_pkg::ST_NORMAL);
        pulse(wake_irq_idle);
        slow_req = 1'b1;
        exp_q.push_back(standby_pkg::ST_SLOW);
        step(1);
        check({cpu_clk_en, pll_en, periph_clk_en}, {2'h2, 28'h800_0000});
        pulse_op(2'h1);
        check(mode_state, standby_pkg::ST_SLOW);
        step(1);
        exp_q.push_back(standby_pkg::ST_IDLE_DOZE);
        exp_q.push_back(standby_pkg::ST_SLOW);
        pulse_op(2'h2);
        pulse(wake_irq_idle);
        check(mode_state, standby_pkg::ST_SLOW);
        exp_q.push_back(standby_pkg::ST_NORMAL);
        slow_req = 1'b0;
        step(1);
        standby_select = standby_pkg::SEL_SLEEP_DEF;
        exp_q.push_back(standby_pkg::ST_SLEEP);
        exp_q.push_back(standby_pkg::ST_NORMAL);
        pulse_op(2'h1);
        sys_rst = 1'b1;
        step(1);
        sys_rst = 1'b0;
        check({cpu_clk_en, high_osc_en, pll_en, core_frozen}, 4'he);
        complete_run();
    end
endmodule : test_standby_mode_controller
`default_nettype wire
